/* File: dv/pwm_frequency_reference_input_assertions.sv */
// Concurrent checks on the ports of the PWM / repetition frequency input.
`timescale 1ns/10ps
`default_nettype none
`include "pwm_ref_regs.vh"
module pwm_ref_checker (
    input wire logic        CLOCK_I,
    input wire logic        RESETN_I,
    input wire logic [7:0]  ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic        WR_I,
    input wire logic        RD_I,
    input wire logic [31:0] RDATA_O,
    input wire logic        DIGITAL_INPUT_TWO_I,
    input wire logic        DIGITAL_INPUT_THREE_I,
    input wire logic        DIGITAL_INPUT_SIX_I,
    input wire logic        DIGITAL_INPUT_TWO_O,
    input wire logic        DIGITAL_INPUT_THREE_O,
    input wire logic        DIGITAL_INPUT_SIX_O,
    input wire logic [31:0] FREQ_REF_O,
    input wire logic [31:0] PCT_REF_O,
    input wire logic        FREQ_REF_ACTIVE_O,
    input wire logic        PCT_REF_ACTIVE_O,
    input wire logic        SIGNAL_PRESENT_O
);
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RESETN_I);
    // ==========================================================
    // Shadow of mode and source selection
    logic [7:0]  mode_q; // Last mode written
    logic [15:0] src_q;  // Last source selection written
    logic        c2;     // Terminal two claimed
    logic        c3;     // Terminal three claimed
    logic        c6;     // Terminal six claimed
    // Follows the bus writes so claims can be judged without looking inside
    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            mode_q <= 8'h00;
            src_q  <= 16'h0000;
        end else if (WR_I && ADDR_I == `ADDR_MODE) begin
            mode_q <= WDATA_I[7:0];
        end else if (WR_I && ADDR_I == `ADDR_REF_SRC) begin
            src_q <= WDATA_I[15:0];
        end
    end
    assign c2 = mode_q inside {8'h02, 8'h0c, 8'h15, 8'h16, 8'h79, 8'h7a};
    assign c3 = mode_q inside {8'h03, 8'h0d, 8'h1f, 8'h20, 8'h83, 8'h84};
    assign c6 = mode_q inside {8'h06, 8'h10, 8'h3d, 8'h3e, 8'ha1, 8'ha2};
    // ==========================================================
    // Checks; steady claims only, so the forcing may be registered or not
    AST_PASS_TWO: assert property ($past(RESETN_I) && c2 == $past(c2) |->
        DIGITAL_INPUT_TWO_O == (c2 ? 1'b0 : $past(DIGITAL_INPUT_TWO_I)))
        else $error("terminal two forwarding wrong");
    AST_PASS_THREE: assert property ($past(RESETN_I) && c3 == $past(c3) |->
        DIGITAL_INPUT_THREE_O == (c3 ? 1'b0 : $past(DIGITAL_INPUT_THREE_I)))
        else $error("terminal three forwarding wrong");
    AST_PASS_SIX: assert property ($past(RESETN_I) && c6 == $past(c6) |->
        DIGITAL_INPUT_SIX_O == (c6 ? 1'b0 : $past(DIGITAL_INPUT_SIX_I)))
        else $error("terminal six forwarding wrong");
    AST_FREQ_ACTIVE: assert property (FREQ_REF_ACTIVE_O == (src_q[7:0] == `SRC_PWM))
        else $error("frequency source flag wrong");
    AST_PCT_ACTIVE: assert property (PCT_REF_ACTIVE_O == (src_q[15:8] == `SRC_PWM))
        else $error("percentage source flag wrong");
    AST_FREQ_IDLE: assert property (!FREQ_REF_ACTIVE_O [*2] |-> FREQ_REF_O == 32'h0)
        else $error("frequency reference without source");
    AST_PCT_IDLE: assert property (!PCT_REF_ACTIVE_O [*2] |-> PCT_REF_O == 32'h0)
        else $error("percentage reference without source");
    AST_MODE_OFF: assert property ((mode_q == 8'h00) [*4] |->
        FREQ_REF_O == 32'h0 && PCT_REF_O == 32'h0)
        else $error("value while off");
    AST_RDATA_IDLE: assert property (!$past(RD_I) |-> RDATA_O == 32'h0)
        else $error("read data outside read cycle");
    AST_RESTART: assert property (WR_I && ADDR_I == `ADDR_MODE && WDATA_I[7:0] != mode_q |=>
        ##1 !SIGNAL_PRESENT_O [*2])
        else $error("present kept across mode change");
endmodule
bind pwm_frequency_reference_input pwm_ref_checker u_chk (
    .CLOCK_I(CLOCK_I), .RESETN_I(RESETN_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
    .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
    .DIGITAL_INPUT_TWO_I(DIGITAL_INPUT_TWO_I), .DIGITAL_INPUT_THREE_I(DIGITAL_INPUT_THREE_I),
    .DIGITAL_INPUT_SIX_I(DIGITAL_INPUT_SIX_I), .DIGITAL_INPUT_TWO_O(DIGITAL_INPUT_TWO_O),
    .DIGITAL_INPUT_THREE_O(DIGITAL_INPUT_THREE_O), .DIGITAL_INPUT_SIX_O(DIGITAL_INPUT_SIX_O),
    .FREQ_REF_O(FREQ_REF_O), .PCT_REF_O(PCT_REF_O), .FREQ_REF_ACTIVE_O(FREQ_REF_ACTIVE_O),
    .PCT_REF_ACTIVE_O(PCT_REF_ACTIVE_O), .SIGNAL_PRESENT_O(SIGNAL_PRESENT_O));
`default_nettype wire

/* File: dv/pwm_frequency_reference_input_tb.sv */
// Self-checking bench for the PWM / repetition frequency input.
`timescale 1ns/10ps
`default_nettype none
`include "pwm_ref_regs.vh"
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin miscompares++; \
    $display("unexpected %s exp %h got %h", nm, ex, got); end end
module pwm_frequency_reference_input_tb;
    logic        clk = 1'b0;        // 200 MHz
    logic        rst_n = 1'b0;      // Active low reset
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [31:0] rdata, fref, pref;
    logic [2:0]  din = 3'h0;        // Terminals six, three, two
    logic [2:0]  dout;
    logic        fact, pact, pres, pulse;
    logic        rd_seen = 1'b0;    // Read accepted last edge
    logic [1:0]  sel = 2'h0;        // Terminal carrying the pulses
    logic [15:0] high = 16'h190;    // Pulse high time
    logic [15:0] hr;                // Random high time
    logic [31:0] seed = 32'heea3;
    logic [31:0] noise = 32'heea3;  // Levels for terminals without pulses
    logic [31:0] exp_q[$];          // Expected read data, oldest first
    logic [31:0] exp_r;             // Oldest note, taken off once per read
    int          miscompares = 0;
    int          num_checks = 0;
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    always #2.5 clk = ~clk;
    // ==========================================================
    // Far side and terminal routing; terminals not carrying the pulses toggle randomly
    pwm_pulse_source SRC (.clk_i(clk), .period_i(16'h640), .high_i(high), .pulse_o(pulse));
    always @(posedge clk) begin
        noise <= xs(noise);
        din   <= {sel == 2'h2 ? pulse : noise[2], sel == 2'h1 ? pulse : noise[1],
                  sel == 2'h0 ? pulse : noise[0]};
    end
    // Short loss timeout keeps each measurement brief
    pwm_frequency_reference_input #(.TIMEOUT_CYC(4000)) DUT (
        .CLOCK_I(clk), .RESETN_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
        .RD_I(rd), .RDATA_O(rdata), .DIGITAL_INPUT_TWO_I(din[0]),
        .DIGITAL_INPUT_THREE_I(din[1]), .DIGITAL_INPUT_SIX_I(din[2]),
        .DIGITAL_INPUT_TWO_O(dout[0]), .DIGITAL_INPUT_THREE_O(dout[1]),
        .DIGITAL_INPUT_SIX_O(dout[2]), .FREQ_REF_O(fref), .PCT_REF_O(pref),
        .FREQ_REF_ACTIVE_O(fact), .PCT_REF_ACTIVE_O(pact), .SIGNAL_PRESENT_O(pres));
    // ==========================================================
    // Bus tasks; each strobe lasts exactly one cycle
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        exp_q.push_back(e);
        @(posedge clk);
        rd   <= 1'b0;
    endtask
    // Data stand only in the cycle after the strobe, so compare mid-cycle there
    always @(posedge clk) rd_seen <= rd;
    always @(negedge clk) begin
        if (rd_seen) begin
            exp_r = exp_q.pop_front();
            `CHK("rdata", exp_r, rdata)
        end
    end
    // Route pulses, set the mode, allow two closing edges, then read the value
    task automatic measure(input logic [7:0] m, input logic [1:0] s, input logic [15:0] h,
                           input logic [31:0] e);
        @(posedge clk);
        sel  <= s;
        high <= h;
        wr_reg(`ADDR_MODE, {24'h0, m});
        repeat (4820) @(posedge clk);
        rd_reg(`ADDR_ACTUAL, e);
    endtask
    task automatic report_and_stop();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // ==========================================================
    // Main sequence; period is 1600 cycles, 125 kHz
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(`ADDR_MODE, 32'h0);
        rd_reg(`ADDR_DIVIDER, 32'h400);
        rd_reg(`ADDR_GAIN, 32'h3e8);
        rd_reg(`ADDR_OFFSET, 32'h0);
        rd_reg(`ADDR_MAX_FREQ, 32'h1388);
        rd_reg(`ADDR_MAX_PCT, 32'h2710);
        wr_reg(8'h2c, 32'h1234);
        rd_reg(8'h2c, 32'h0);
        wr_reg(`ADDR_DIVIDER, 32'h0);
        rd_reg(`ADDR_DIVIDER, 32'h1);
        wr_reg(`ADDR_DIVIDER, 32'h2328);
        rd_reg(`ADDR_DIVIDER, 32'h2000);
        wr_reg(`ADDR_GAIN, 32'h1);
        rd_reg(`ADDR_GAIN, 32'h32);
        wr_reg(`ADDR_GAIN, 32'h3e8);
        hr = 16'h10 * (16'h1 + 16'(xs(seed) % 98));
        measure(8'h00, 2'h0, 16'h190, 32'h0);
        measure(8'h02, 2'h0, 16'h190, 32'h9c4);
        measure(8'h0d, 2'h1, 16'h190, 32'hffffec78);
        measure(8'h06, 2'h2, hr, {16'h0, hr} * 32'h19 / 32'h4);
        wr_reg(`ADDR_DIVIDER, 32'h1);
        measure(8'h16, 2'h0, 16'h320, 32'h2710);
        wr_reg(`ADDR_DIVIDER, 32'hfa0);
        measure(8'h1f, 2'h1, 16'h320, 32'hc35);
        measure(8'h3e, 2'h2, 16'h320, 32'h186a);
        measure(8'h79, 2'h0, 16'h320, 32'hfffff3cb);
        wr_reg(`ADDR_OFFSET, 32'h3e8);
        wr_reg(`ADDR_GAIN, 32'h7d0);
        wr_reg(`ADDR_REF_SRC, 32'h2020);
        measure(8'h02, 2'h0, 16'h190, 32'h1770);
        rd_reg(`ADDR_FREQ_REF, 32'hbb8);
        rd_reg(`ADDR_PCT_REF, 32'h1770);
        repeat (4) @(posedge clk);
        report_and_stop();
    end
    // Hang guard, well beyond the roughly 43500 cycles the sequence needs
    initial begin
        repeat (90000) @(posedge clk);
        miscompares++;
        report_and_stop();
    end
endmodule
`default_nettype wire

/* File: dv/pwm_pulse_source.sv */
// Behavioural pulse source standing in for the external PWM or pulse generator.
`timescale 1ns/10ps
`default_nettype none
module pwm_pulse_source (
    input  wire logic        clk_i,
    input  wire logic [15:0] period_i,
    input  wire logic [15:0] high_i,
    output var  logic        pulse_o
);
    // ==========================================================
    // Period counter
    logic [15:0] cnt_q = 16'h0000; // Position within the period
    // High for the first high_i cycles; the bench keeps the rate inside 50 Hz..150 kHz
    always @(posedge clk_i) begin
        cnt_q   <= (cnt_q >= period_i - 16'h0001) ? 16'h0000 : cnt_q + 16'h0001;
        pulse_o <= (cnt_q < high_i);
    end
endmodule
`default_nettype wire

/* File: hdl/pwm_frequency_reference_input.v */
// PWM duty cycle and repetition frequency evaluation into a signed reference value.
`timescale 1ns/10ps
`default_nettype none
`include "pwm_ref_regs.vh"

module pwm_frequency_reference_input #(
    // Cycles without an edge before the signal counts as lost
    parameter TIMEOUT_CYC = `CLK_HZ / `MIN_SIG_HZ
) (
    input  wire        CLOCK_I,
    input  wire        RESETN_I,
    input  wire [7:0]  ADDR_I,
    input  wire [31:0] WDATA_I,
    input  wire        WR_I,
    input  wire        RD_I,
    output wire [31:0] RDATA_O,
    input  wire        DIGITAL_INPUT_TWO_I,
    input  wire        DIGITAL_INPUT_THREE_I,
    input  wire        DIGITAL_INPUT_SIX_I,
    output wire        DIGITAL_INPUT_TWO_O,
    output wire        DIGITAL_INPUT_THREE_O,
    output wire        DIGITAL_INPUT_SIX_O,
    output wire [31:0] FREQ_REF_O,
    output wire [31:0] PCT_REF_O,
    output wire        FREQ_REF_ACTIVE_O,
    output wire        PCT_REF_ACTIVE_O,
    output wire        SIGNAL_PRESENT_O
);

// ==========================================================
// Mode kinds
localparam [4:0] K_OFF = 5'b00001;
localparam [4:0] K_UNI = 5'b00010;
localparam [4:0] K_BI  = 5'b00100;
localparam [4:0] K_ONE = 5'b01000;
localparam [4:0] K_TWO = 5'b10000;

// Cycle count widths: timeout of 4e6 cycles fits in 24 bits
localparam [23:0] TMO = TIMEOUT_CYC[23:0];
localparam [39:0] CLK_SCALED = `CLK_HZ * `FREQ_SCALE_HZ;

// ==========================================================
// Mode decoding functions

// Kind of evaluation for an operating mode; unknown modes act as off
function [4:0] mode_kind;
    input [7:0] m;
    begin
        case (m)
            8'd2, 8'd3, 8'd6:           mode_kind = K_UNI;
            8'd12, 8'd13, 8'd16:        mode_kind = K_BI;
            8'd21, 8'd31, 8'd61,
            8'd121, 8'd131, 8'd161:     mode_kind = K_ONE;
            8'd22, 8'd32, 8'd62,
            8'd122, 8'd132, 8'd162:     mode_kind = K_TWO;
            default:                    mode_kind = K_OFF;
        endcase
    end
endfunction

// Which terminal the mode claims: 0 none, 1 two, 2 three, 3 six
function [1:0] mode_pin;
    input [7:0] m;
    begin
        if (mode_kind(m) == K_OFF) begin
            mode_pin = 2'd0;
        end else if (m == 8'd2 || m == 8'd12 || m == 8'd21 || m == 8'd22 ||
                     m == 8'd121 || m == 8'd122) begin
            mode_pin = 2'd1;
        end else if (m == 8'd3 || m == 8'd13 || m == 8'd31 || m == 8'd32 ||
                     m == 8'd131 || m == 8'd132) begin
            mode_pin = 2'd2;
        end else begin
            mode_pin = 2'd3;
        end
    end
endfunction

// Limit a value to a closed range
function signed [47:0] clamp;
    input signed [47:0] v;
    input signed [47:0] lo;
    input signed [47:0] hi;
    begin
        if (v < lo) begin
            clamp = lo;
        end else if (v > hi) begin
            clamp = hi;
        end else begin
            clamp = v;
        end
    end
endfunction

// ==========================================================
// Software registers
reg  [7:0]  mode_q;      // Operating mode
reg  [13:0] divider_q;   // Frequency divider
reg  [15:0] offset_q;    // Signed offset, hundredths of percent
reg  [13:0] gain_q;      // Gain, tenths of percent
reg  [15:0] ref_src_q;   // Low byte: frequency source, high byte: percentage source
reg  [15:0] max_freq_q;  // Maximum frequency, hundredths of Hz
reg  [15:0] max_pct_q;   // Maximum percentage, hundredths of percent
reg  [31:0] rdata_q;     // Read data, valid the cycle after the strobe
reg  [31:0] rdata_d;

// Decoded mode, combinational from the register
wire [4:0]  kind      = mode_kind(mode_q);
wire [1:0]  pin       = mode_pin(mode_q);
wire        negative  = mode_q > 8'd120;

// Written value seen as signed for clamping
wire signed [47:0] wr_s = {{16{WDATA_I[31]}}, WDATA_I};

// Saturated write values; the clamp is wide, the registers keep only the low field
wire signed [47:0] wr_div  = clamp(wr_s, {34'd0, `DIV_MIN}, {34'd0, `DIV_MAX});
wire signed [47:0] wr_ofs  = clamp(wr_s, -{{32{1'b0}}, `OFS_LIMIT},
                                   {{32{1'b0}}, `OFS_LIMIT});
wire signed [47:0] wr_gain = clamp(wr_s, {34'd0, `GAIN_MIN}, {34'd0, `GAIN_MAX});

// Register writes; out-of-range divider, offset and gain values saturate to the legal limits
always @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
        mode_q     <= `RST_MODE;
        divider_q  <= `RST_DIVIDER;
        offset_q   <= `RST_OFFSET;
        gain_q     <= `RST_GAIN;
        ref_src_q  <= `RST_REF_SRC;
        max_freq_q <= `RST_MAX_FREQ;
        max_pct_q  <= `RST_MAX_PCT;
    end else if (WR_I) begin
        if (ADDR_I == `ADDR_MODE) begin
            mode_q <= WDATA_I[7:0];
        end else if (ADDR_I == `ADDR_DIVIDER) begin
            // Divider held within 1..8192
            divider_q <= wr_div[13:0];
        end else if (ADDR_I == `ADDR_OFFSET) begin
            // Offset held within -100.00 .. 100.00 percent
            offset_q <= wr_ofs[15:0];
        end else if (ADDR_I == `ADDR_GAIN) begin
            // Gain held within 5.0 .. 1000.0 percent
            gain_q <= wr_gain[13:0];
        end else if (ADDR_I == `ADDR_REF_SRC) begin
            ref_src_q <= WDATA_I[15:0];
        end else if (ADDR_I == `ADDR_MAX_FREQ) begin
            max_freq_q <= WDATA_I[15:0];
        end else if (ADDR_I == `ADDR_MAX_PCT) begin
            max_pct_q <= WDATA_I[15:0];
        end
    end
end

// ==========================================================
// Input selection and edge detection

// Terminal chosen by the mode; idle low when nothing is claimed
reg sel_in;
always @* begin
    case (pin)
        2'd1:    sel_in = DIGITAL_INPUT_TWO_I;
        2'd2:    sel_in = DIGITAL_INPUT_THREE_I;
        2'd3:    sel_in = DIGITAL_INPUT_SIX_I;
        default: sel_in = 1'b0;
    endcase
end

reg  in_q;         // Previous level of the selected input
reg  [7:0] mode_seen_q; // Mode at the last cycle, to restart on a change
wire rise = sel_in & ~in_q;
wire fall = ~sel_in & in_q;
wire restart = mode_seen_q != mode_q;
// Double evaluation measures the interval between any two edges
wire event_hit = (kind == K_TWO) ? (rise | fall) : rise;

// ==========================================================
// Period and high-time capture
reg [23:0] cnt_q;      // Cycles since the last counted edge
reg [23:0] hi_cnt_q;   // High cycles since the last rising edge
reg [23:0] per_q;      // Last full interval
reg [23:0] hi_q;       // High time within that interval
reg        armed_q;    // One edge seen, next one closes an interval
reg        present_q;  // A full interval was measured recently

// Counting runs on the system clock; the timeout keeps stale data from
// standing forever when the source stops below the lowest frequency
always @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
        in_q        <= 1'b0;
        mode_seen_q <= `RST_MODE;
        cnt_q       <= 24'h00_0000;
        hi_cnt_q    <= 24'h00_0000;
        per_q       <= 24'h00_0000;
        hi_q        <= 24'h00_0000;
        armed_q     <= 1'b0;
        present_q   <= 1'b0;
    end else begin
        in_q        <= sel_in;
        mode_seen_q <= mode_q;
        if (restart || kind == K_OFF) begin
            // New mode or off: clear counts, armed and present; per_q and hi_q keep their values
            cnt_q     <= 24'h00_0000;
            hi_cnt_q  <= 24'h00_0000;
            armed_q   <= 1'b0;
            present_q <= 1'b0;
        end else if (event_hit) begin
            // Close the interval on the chosen edge
            per_q     <= cnt_q + 24'h00_0001;
            hi_q      <= hi_cnt_q;
            present_q <= armed_q;
            armed_q   <= 1'b1;
            cnt_q     <= 24'h00_0000;
            // The rising-edge cycle is already high, so it starts the count
            hi_cnt_q  <= rise ? 24'h00_0001 : hi_cnt_q;
        end else if (cnt_q >= TMO) begin
            // Below the slowest frequency the signal counts as absent
            present_q <= 1'b0;
            armed_q   <= 1'b0;
        end else begin
            cnt_q    <= cnt_q + 24'h00_0001;
            hi_cnt_q <= sel_in ? hi_cnt_q + 24'h00_0001 : hi_cnt_q;
        end
    end
end

// ==========================================================
// Raw measured value in hundredths of percent

reg  signed [47:0] raw;
wire [39:0] per_div = per_q * divider_q;
wire [39:0] freq_c  = (per_div == 40'd0) ? 40'd0 : CLK_SCALED / per_div;

// Duty cycle: a static level reads as 0 or 100 percent. Frequency:
// scaled hertz map one to one onto percent, so 100 Hz is 100.00 %
always @* begin
    raw = 48'sd0;
    case (kind)
        K_UNI, K_BI: begin
            if (!present_q || per_q == 24'd0) begin
                raw = in_q ? `PCT_FULL : 48'sd0;
            end else begin
                raw = $signed({24'd0, hi_q}) * `PCT_FULL
                      / $signed({24'd0, per_q});
            end
            if (kind == K_BI) begin
                raw = raw + raw - `PCT_FULL;
            end
        end
        K_ONE, K_TWO: begin
            raw = present_q ? $signed({8'd0, freq_c}) : 48'sd0;
            if (negative) begin
                raw = -raw;
            end
        end
        default: raw = 48'sd0;
    endcase
end

// ==========================================================
// Offset, gain and saturation

wire signed [47:0] ofs_s  = {{32{offset_q[15]}}, offset_q};
wire signed [47:0] gain_s = {34'd0, gain_q};
wire signed [47:0] adj    = ofs_s + raw * gain_s / `GAIN_UNITY;
// Unipolar duty keeps to 0..100 %, every other mode to +-100 %
wire signed [47:0] lo_lim = (kind == K_UNI) ? 48'sd0 : -`PCT_FULL;
wire signed [47:0] val_c  = (kind == K_OFF) ? 48'sd0 :
                            clamp(adj, lo_lim, `PCT_FULL);

reg  [31:0] actual_q;    // Measured value in hundredths of percent
reg  [31:0] freq_ref_q;  // Frequency reference, hundredths of Hz
reg  [31:0] pct_ref_q;   // Percentage reference, hundredths of percent
reg         two_q;
reg         three_q;
reg         six_q;

wire f_src = ref_src_q[7:0]  == `SRC_PWM;
wire p_src = ref_src_q[15:8] == `SRC_PWM;

// Reference against the selected maximum; a source other than the
// PWM input leaves the reference at zero
wire signed [47:0] f_c = val_c * $signed({32'd0, max_freq_q}) / `PCT_FULL;
wire signed [47:0] p_c = val_c * $signed({32'd0, max_pct_q}) / `PCT_FULL;

// Result registers; one cycle behind the measurement
always @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
        actual_q   <= 32'h0000_0000;
        freq_ref_q <= 32'h0000_0000;
        pct_ref_q  <= 32'h0000_0000;
        two_q      <= 1'b0;
        three_q    <= 1'b0;
        six_q      <= 1'b0;
    end else begin
        actual_q   <= val_c[31:0];
        freq_ref_q <= f_src ? f_c[31:0] : 32'h0000_0000;
        pct_ref_q  <= p_src ? p_c[31:0] : 32'h0000_0000;
        // A claimed terminal reads low to every other function
        two_q      <= DIGITAL_INPUT_TWO_I   & (pin != 2'd1);
        three_q    <= DIGITAL_INPUT_THREE_I & (pin != 2'd2);
        six_q      <= DIGITAL_INPUT_SIX_I   & (pin != 2'd3);
    end
end

// ==========================================================
// Register reads; unmapped addresses read as zero

always @* begin
    rdata_d = 32'h0000_0000;
    if (ADDR_I == `ADDR_MODE) begin
        rdata_d = {24'd0, mode_q};
    end else if (ADDR_I == `ADDR_DIVIDER) begin
        rdata_d = {18'd0, divider_q};
    end else if (ADDR_I == `ADDR_OFFSET) begin
        rdata_d = {{16{offset_q[15]}}, offset_q};
    end else if (ADDR_I == `ADDR_GAIN) begin
        rdata_d = {18'd0, gain_q};
    end else if (ADDR_I == `ADDR_REF_SRC) begin
        rdata_d = {16'd0, ref_src_q};
    end else if (ADDR_I == `ADDR_MAX_FREQ) begin
        rdata_d = {16'd0, max_freq_q};
    end else if (ADDR_I == `ADDR_MAX_PCT) begin
        rdata_d = {16'd0, max_pct_q};
    end else if (ADDR_I == `ADDR_ACTUAL) begin
        rdata_d = actual_q;
    end else if (ADDR_I == `ADDR_FREQ_REF) begin
        rdata_d = freq_ref_q;
    end else if (ADDR_I == `ADDR_PCT_REF) begin
        rdata_d = pct_ref_q;
    end else if (ADDR_I == `ADDR_STATUS) begin
        rdata_d = {29'd0, in_q, armed_q, present_q};
    end
end

// Read data stands only in the cycle after the strobe
always @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
        rdata_q <= 32'h0000_0000;
    end else begin
        rdata_q <= RD_I ? rdata_d : 32'h0000_0000;
    end
end

// ==========================================================
// Outputs
assign RDATA_O               = rdata_q;
assign DIGITAL_INPUT_TWO_O   = two_q;
assign DIGITAL_INPUT_THREE_O = three_q;
assign DIGITAL_INPUT_SIX_O   = six_q;
assign FREQ_REF_O            = freq_ref_q;
assign PCT_REF_O             = pct_ref_q;
assign FREQ_REF_ACTIVE_O     = f_src;
assign PCT_REF_ACTIVE_O      = p_src;
assign SIGNAL_PRESENT_O      = present_q;

endmodule
`default_nettype wire

/* File: hdl/pwm_ref_regs.vh */
// Register map, field limits and timing constants for the PWM / repetition frequency input.
//
// What this block does
// - Mode zero gives a value of zero
// - Modes 2,3,6 map duty unipolar 0..100%
// - Modes 12,13,16 map duty bipolar -100..100%
// - Modes 21,31,61 count one edge, positive
// - Modes 22,32,62 count both edges, positive
// - Modes 121..162 same as 21..62, negative sign
// - Claimed input is withheld from other functions
// - Evaluate signals between 50 Hz and 150 kHz
// - Divider 1..8192, default 1024, scales frequency
// - Scaled 100 Hz equals 100 percent
// - Value is offset plus duty times gain
// - Source 32 refers value to maximum limit
// - Measured value readable as actual value
`ifndef PWM_REF_REGS_VH
`define PWM_REF_REGS_VH

// ==========================================================
// Register byte addresses
`define ADDR_MODE       8'h00
`define ADDR_DIVIDER    8'h04
`define ADDR_OFFSET     8'h08
`define ADDR_GAIN       8'h0c
`define ADDR_REF_SRC    8'h10
`define ADDR_MAX_FREQ   8'h14
`define ADDR_MAX_PCT    8'h18
`define ADDR_ACTUAL     8'h1c
`define ADDR_FREQ_REF   8'h20
`define ADDR_PCT_REF    8'h24
`define ADDR_STATUS     8'h28

// ==========================================================
// Reset values (hundredths of Hz or percent, tenths for gain)
`define RST_MODE        8'h00
`define RST_DIVIDER     14'h0400
`define RST_OFFSET      16'h0000
`define RST_GAIN        14'h03e8
`define RST_REF_SRC     16'h0000
`define RST_MAX_FREQ    16'h1388
`define RST_MAX_PCT     16'h2710

// ==========================================================
// Field limits
`define DIV_MIN         14'h0001
`define DIV_MAX         14'h2000
`define GAIN_MIN        14'h0032
`define GAIN_MAX        14'h2710
`define GAIN_UNITY      48'sh0000_0000_03e8
`define OFS_LIMIT       16'sh2710
`define PCT_FULL        48'sh0000_0000_2710
`define SRC_PWM         8'h20
`define FREQ_SCALE_HZ   40'h00_0000_0064

// ==========================================================
// Timing: clock rate and slowest evaluated signal
`define CLK_HZ          200000000
`define MIN_SIG_HZ      50
`define MAX_SIG_HZ      150000

`endif
